// file: pol_prot_pkg.sv
package pol_prot_pkg;

	// Clock and timing.
	localparam int CLK_HZ       = 125_000_000;
	localparam int DELAY_NS     = 6000;
	localparam int DELAY_CYC    = (DELAY_NS * (CLK_HZ / 1_000_000)) / 1000;
	localparam int RETRY_MS     = 130;
	localparam int RETRY_CYC    = RETRY_MS * (CLK_HZ / 1000);
	localparam int DCNT_W       = 10;
	localparam int RCNT_W       = 24;

	// Measurement widths: voltages in millivolts, temperature in signed degrees C.
	localparam int VOLT_W       = 13;
	localparam int TEMP_W       = 10;
	localparam int PROD_W       = 18;

	// Fractions of the setpoint in twentieths (5 percent steps).
	localparam logic [4:0] STEP_DEN      = 5'h14;
	localparam logic [4:0] UV_BASE_K     = 5'h0F;
	localparam logic [4:0] UV_TOP_K      = 5'h11;
	localparam logic [4:0] PG_LOW_BASE_K = 5'h12;
	localparam logic [4:0] PG_LOW_TOP_K  = 5'h13;
	localparam logic [4:0] PG_HIGH_K     = 5'h16;

	// Temperatures in degrees C.
	localparam logic signed [TEMP_W-1:0] OT_TRIP_C    = 10'sh082;
	localparam logic signed [TEMP_W-1:0] OT_RESTART_C = 10'sh078;
	localparam logic signed [TEMP_W-1:0] WARN_SET_C   = 10'sh078;
	localparam logic signed [TEMP_W-1:0] WARN_CLR_C   = 10'sh075;

	// Tracking limit in millivolts either way.
	localparam logic [VOLT_W:0] TRK_LIMIT_MV = 14'h00FA;

	// Register map, byte addresses.
	localparam int ADDR_W = 5;
	localparam logic [ADDR_W-1:0] ADDR_CTRL     = 5'h00;
	localparam logic [ADDR_W-1:0] ADDR_STATUS   = 5'h04;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 5'h08;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_EN   = 5'h0C;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_CLR  = 5'h10;
	localparam logic [ADDR_W-1:0] ADDR_REENABLE = 5'h14;

	typedef struct packed {
		logic [1:0] pg_low_sel;
		logic [1:0] uv_thr_sel;
		logic       trk_latch;
		logic       trk_en;
		logic       ot_latch;
		logic       uv_latch;
	} ctrl_t;
	localparam int    CTRL_W   = 8;
	localparam ctrl_t CTRL_RST = 8'h00;

	typedef struct packed {
		logic pg_change;
		logic warn_rise;
		logic trk_trip;
		logic ot_trip;
		logic uv_trip;
	} evt_t;
	localparam int   EVT_W   = 5;
	localparam evt_t EVT_RST = 5'h00;

	typedef struct packed {
		logic turn_off;
		logic power_good;
		logic ot_warn;
		logic trk_fault;
		logic ot_fault;
		logic uv_fault;
	} status_t;
	localparam int STATUS_W = 6;

	typedef enum logic [1:0] {
		ST_ON    = 2'b00,
		ST_RETRY = 2'b01,
		ST_COOL  = 2'b10,
		ST_LATCH = 2'b11
	} prot_state_t;

endpackage

// file: pol_fault_protection_monitor.sv
// Functional notes
// - Undervoltage below 75..85 percent setpoint, 5 percent steps.
// - Latching or non-latching; non-latching undervoltage and tracking retry every 130 ms.
// - Turn-off 6 us after fault threshold crossing.
// - Overtemperature trips 130 C, restarts at 120 C.
// - Tracking off by default; ramp-up only, 250 mV.
// - Warning at 120 C, 3 C hysteresis, status only.
// - Warning raised 6 us after crossing.
// - Power-good high inside window, low outside.
// - Window low 90..95 percent, high fixed 110 percent.
// - Power-good updates 6 us after crossing.
//
// The Avalon-MM register port and the register offsets were decided locally.
`timescale 1ns/1ps

module prot_deglitch (
	// Clock and reset
	input  wire logic clock,
	input  wire logic rst_n,
	// Condition in, filtered level out
	input  wire logic raw,
	output logic      level_q
);
	logic [pol_prot_pkg::DCNT_W-1:0] cnt_q;
	logic [pol_prot_pkg::DCNT_W-1:0] cnt_d;
	logic                            level_d;

	// The level follows the raw condition only once it has disagreed for the full delay.
	always_comb begin
		cnt_d   = '0;
		level_d = level_q;
		if (raw != level_q) begin
			if (cnt_q == pol_prot_pkg::DCNT_W'(pol_prot_pkg::DELAY_CYC - 1)) begin
				level_d = raw;
			end else begin
				cnt_d = cnt_q + 1'b1;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q   <= '0;
			level_q <= 1'b0;
		end else begin
			cnt_q   <= cnt_d;
			level_q <= level_d;
		end
	end
endmodule // prot_deglitch

module pol_fault_protection_monitor #(
	parameter int RETRY_CYCLES = pol_prot_pkg::RETRY_CYC
) (
	// Clock and reset
	input  wire logic                                    clock,
	input  wire logic                                    rst_n,
	// Measurements
	input  wire logic [pol_prot_pkg::VOLT_W-1:0]         vout_mv,
	input  wire logic [pol_prot_pkg::VOLT_W-1:0]         vset_mv,
	input  wire logic [pol_prot_pkg::VOLT_W-1:0]         vramp_mv,
	input  wire logic                                    ramping_up,
	input  wire logic signed [pol_prot_pkg::TEMP_W-1:0]  temp_c,
	// Converter and system outputs
	output logic                                         turn_off,
	output logic                                         power_good_output,
	output logic                                         irq,
	// Avalon-MM slave
	input  wire logic [pol_prot_pkg::ADDR_W-1:0]         avs_address,
	input  wire logic                                    avs_read,
	input  wire logic                                    avs_write,
	input  wire logic [31:0]                             avs_writedata,
	output logic      [31:0]                             avs_readdata,
	output logic                                         avs_waitrequest
);
	function automatic logic [pol_prot_pkg::PROD_W-1:0] scale(
		input logic [pol_prot_pkg::VOLT_W-1:0] v,
		input logic [4:0]                      k
	);
		return {5'h00, v} * {13'h0000, k};
	endfunction

	pol_prot_pkg::ctrl_t                  ctrl_q;
	pol_prot_pkg::ctrl_t                  ctrl_d;
	pol_prot_pkg::evt_t                   sticky_q;
	pol_prot_pkg::evt_t                   sticky_d;
	pol_prot_pkg::evt_t                   en_q;
	pol_prot_pkg::evt_t                   en_d;
	pol_prot_pkg::evt_t                   evt;
	pol_prot_pkg::status_t                status;
	pol_prot_pkg::prot_state_t            st_q;
	pol_prot_pkg::prot_state_t            st_d;
	logic [pol_prot_pkg::RCNT_W-1:0]      rcnt_q;
	logic [pol_prot_pkg::RCNT_W-1:0]      rcnt_d;
	logic [2:0]                           fault_q;
	logic [2:0]                           fault_d;
	logic [31:0]                          rdata_d;
	logic                                 wait_d;
	logic                                 irq_d;
	logic                                 off_d;
	logic                                 warn_prev_q;
	logic                                 pg_prev_q;
	logic                                 wr_ok;
	logic                                 clr_hit;
	logic                                 reen_hit;
	logic [4:0]                           uv_k;
	logic [4:0]                           pg_k;
	logic [pol_prot_pkg::PROD_W-1:0]      vout_x;
	logic signed [pol_prot_pkg::VOLT_W:0] dev;
	logic [pol_prot_pkg::VOLT_W:0]        dev_abs;
	logic                                 conv_on;
	logic                                 uv_raw;
	logic                                 ot_raw;
	logic                                 trk_raw;
	logic                                 warn_raw;
	logic                                 pg_raw;
	logic                                 uv_lvl;
	logic                                 ot_lvl;
	logic                                 trk_lvl;
	logic                                 warn_lvl;

	// Threshold selection, clamped to the top step.
	always_comb begin
		uv_k = pol_prot_pkg::UV_BASE_K + {3'h0, ctrl_q.uv_thr_sel};
		if (uv_k > pol_prot_pkg::UV_TOP_K) begin
			uv_k = pol_prot_pkg::UV_TOP_K;
		end
		pg_k = pol_prot_pkg::PG_LOW_BASE_K + {3'h0, ctrl_q.pg_low_sel};
		if (pg_k > pol_prot_pkg::PG_LOW_TOP_K) begin
			pg_k = pol_prot_pkg::PG_LOW_TOP_K;
		end
	end

	assign vout_x   = scale(vout_mv, pol_prot_pkg::STEP_DEN);
	assign conv_on  = !turn_off;
	assign dev      = $signed({1'b0, vout_mv}) - $signed({1'b0, vramp_mv});
	assign dev_abs  = dev[pol_prot_pkg::VOLT_W] ? 14'(-dev) : 14'(dev);
	// Undervoltage is not judged during the ramp, where the output is legitimately low.
	assign uv_raw   = conv_on && !ramping_up && (vout_x < scale(vset_mv, uv_k));
	assign ot_raw   = ot_lvl ? (temp_c > pol_prot_pkg::OT_RESTART_C)
	                         : (temp_c >= pol_prot_pkg::OT_TRIP_C);
	assign trk_raw  = ctrl_q.trk_en && ramping_up && conv_on
	                  && (dev_abs > pol_prot_pkg::TRK_LIMIT_MV);
	assign warn_raw = warn_lvl ? (temp_c > pol_prot_pkg::WARN_CLR_C)
	                           : (temp_c >= pol_prot_pkg::WARN_SET_C);
	assign pg_raw   = (vout_x >= scale(vset_mv, pg_k))
	                  && (vout_x <= scale(vset_mv, pol_prot_pkg::PG_HIGH_K));

	// Every judgement passes the same filter, so all trip and report delays match.
	prot_deglitch u_uv (
		.clock   (clock),
		.rst_n   (rst_n),
		.raw     (uv_raw),
		.level_q (uv_lvl)
	);
	prot_deglitch u_ot (
		.clock   (clock),
		.rst_n   (rst_n),
		.raw     (ot_raw),
		.level_q (ot_lvl)
	);
	prot_deglitch u_trk (
		.clock   (clock),
		.rst_n   (rst_n),
		.raw     (trk_raw),
		.level_q (trk_lvl)
	);
	prot_deglitch u_warn (
		.clock   (clock),
		.rst_n   (rst_n),
		.raw     (warn_raw),
		.level_q (warn_lvl)
	);
	prot_deglitch u_pg (
		.clock   (clock),
		.rst_n   (rst_n),
		.raw     (pg_raw),
		.level_q (power_good_output)
	);

	assign wr_ok    = avs_write && !avs_waitrequest;
	assign clr_hit  = wr_ok && (avs_address == pol_prot_pkg::ADDR_IRQ_CLR);
	assign reen_hit = wr_ok && (avs_address == pol_prot_pkg::ADDR_REENABLE) && avs_writedata[0];

	// Fault response state machine; fault_q holds {trk, ot, uv} status.
	always_comb begin
		st_d    = st_q;
		rcnt_d  = rcnt_q;
		fault_d = fault_q;
		evt     = pol_prot_pkg::EVT_RST;
		unique case (st_q)
			pol_prot_pkg::ST_ON: begin
				rcnt_d = '0;
				if (ot_lvl) begin
					fault_d[1]  = 1'b1;
					evt.ot_trip = 1'b1;
					st_d = ctrl_q.ot_latch ? pol_prot_pkg::ST_LATCH
					                       : pol_prot_pkg::ST_COOL;
				end else if (trk_lvl) begin
					fault_d[2]   = 1'b1;
					evt.trk_trip = 1'b1;
					st_d = ctrl_q.trk_latch ? pol_prot_pkg::ST_LATCH
					                        : pol_prot_pkg::ST_RETRY;
				end else if (uv_lvl) begin
					fault_d[0]  = 1'b1;
					evt.uv_trip = 1'b1;
					st_d = ctrl_q.uv_latch ? pol_prot_pkg::ST_LATCH
					                       : pol_prot_pkg::ST_RETRY;
				end
			end
			pol_prot_pkg::ST_RETRY: begin
				// The period must outlast the filter delay, or the level left high by
				// the last trip turns the converter off again at once.
				if (rcnt_q == pol_prot_pkg::RCNT_W'(RETRY_CYCLES - 1)) begin
					st_d    = pol_prot_pkg::ST_ON;
					fault_d = '0;
				end else begin
					rcnt_d = rcnt_q + 1'b1;
				end
			end
			pol_prot_pkg::ST_COOL: begin
				if (!ot_lvl) begin
					st_d    = pol_prot_pkg::ST_ON;
					fault_d = '0;
				end
			end
			pol_prot_pkg::ST_LATCH: begin
				// An overtemperature latch also waits for the restart temperature.
				if (reen_hit && !ot_lvl) begin
					st_d    = pol_prot_pkg::ST_ON;
					fault_d = '0;
				end
			end
		endcase
		off_d = (st_d != pol_prot_pkg::ST_ON);
		evt.warn_rise = warn_lvl && !warn_prev_q;
		evt.pg_change = power_good_output != pg_prev_q;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_q        <= pol_prot_pkg::ST_ON;
			rcnt_q      <= '0;
			fault_q     <= '0;
			turn_off    <= 1'b0;
			warn_prev_q <= 1'b0;
			pg_prev_q   <= 1'b0;
		end else begin
			st_q        <= st_d;
			rcnt_q      <= rcnt_d;
			fault_q     <= fault_d;
			turn_off    <= off_d;
			warn_prev_q <= warn_lvl;
			pg_prev_q   <= power_good_output;
		end
	end

	assign status = {turn_off, power_good_output, warn_lvl, fault_q};

	// Bus slave: one wait cycle per access; the access completes when waitrequest is low.
	always_comb begin
		ctrl_d  = ctrl_q;
		en_d    = en_q;
		rdata_d = avs_readdata;
		wait_d  = !((avs_read || avs_write) && avs_waitrequest);
		// A new event wins over a clear in the same cycle.
		sticky_d = (sticky_q & ~(clr_hit ? pol_prot_pkg::evt_t'(avs_writedata[4:0])
		                                 : pol_prot_pkg::EVT_RST)) | evt;
		if (wr_ok && (avs_address == pol_prot_pkg::ADDR_CTRL)) begin
			ctrl_d = avs_writedata[pol_prot_pkg::CTRL_W-1:0];
		end
		if (wr_ok && (avs_address == pol_prot_pkg::ADDR_IRQ_EN)) begin
			en_d = avs_writedata[pol_prot_pkg::EVT_W-1:0];
		end
		if (avs_read && avs_waitrequest) begin
			unique case (avs_address)
				pol_prot_pkg::ADDR_CTRL:     rdata_d = {24'h000000, ctrl_q};
				pol_prot_pkg::ADDR_STATUS:   rdata_d = {26'h0000000, status};
				pol_prot_pkg::ADDR_IRQ_STAT: rdata_d = {27'h0000000, sticky_q};
				pol_prot_pkg::ADDR_IRQ_EN:   rdata_d = {27'h0000000, en_q};
				default:                     rdata_d = 32'h00000000;
			endcase
		end
		irq_d = |(sticky_d & en_d);
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q          <= pol_prot_pkg::CTRL_RST;
			en_q            <= pol_prot_pkg::EVT_RST;
			sticky_q        <= pol_prot_pkg::EVT_RST;
			avs_readdata    <= 32'h00000000;
			avs_waitrequest <= 1'b1;
			irq             <= 1'b0;
		end else begin
			ctrl_q          <= ctrl_d;
			en_q            <= en_d;
			sticky_q        <= sticky_d;
			avs_readdata    <= rdata_d;
			avs_waitrequest <= wait_d;
			irq             <= irq_d;
		end
	end
endmodule // pol_fault_protection_monitor

// file: pol_prot_sva.sv
`timescale 1ns/1ps
module pol_prot_sva (
	// Clock and reset
	input wire logic              clock,
	input wire logic              rst_n,
	// Measurements
	input wire logic [12:0]       vout_mv,
	input wire logic [12:0]       vset_mv,
	input wire logic signed [9:0] temp_c,
	// Outputs and bus
	input wire logic              turn_off,
	input wire logic              power_good_output,
	input wire logic              avs_read,
	input wire logic              avs_write,
	input wire logic              avs_waitrequest
);
	logic [17:0] v20;
	logic [17:0] s18;
	logic [17:0] s19;
	logic [17:0] s22;
	logic [9:0]  hot_q, hi_q, lo_q, win_q, in_q, out_q;
	assign v20 = 18'(vout_mv) * 18'h00014;
	assign s18 = 18'(vset_mv) * 18'h00012;
	assign s19 = 18'(vset_mv) * 18'h00013;
	assign s22 = 18'(vset_mv) * 18'h00016;
	function automatic logic [9:0] run(input logic c, input logic [9:0] q);
		return c ? q + {9'h000, q != 10'h3FF} : 10'h000;
	endfunction
	// Run lengths saturate so a long steady input cannot wrap back under the filter span.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			{hot_q, hi_q, lo_q, win_q, in_q, out_q} <= '0;
		end else begin
			hot_q <= run(temp_c >= pol_prot_pkg::OT_TRIP_C, hot_q);
			hi_q  <= run(v20 > s22, hi_q);
			lo_q  <= run(v20 < s18, lo_q);
			win_q <= run(v20 >= s18 && v20 <= s22, win_q);
			in_q  <= run(v20 >= s19 && v20 <= s22, in_q);
			out_q <= run(v20 < s19 || v20 > s22, out_q);
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	a_ot_trip: assert property (hot_q >= 10'h2F8 |-> turn_off)
		else $error("hot input left the converter on");
	a_pg_above: assert property (hi_q >= 10'h2F8 |-> !power_good_output)
		else $error("power good high above window");
	a_pg_below: assert property (lo_q >= 10'h2F8 |-> !power_good_output)
		else $error("power good high below window");
	a_pg_inside: assert property (in_q >= 10'h2F8 |-> power_good_output)
		else $error("power good low inside window");
	a_pg_rise_late: assert property ($rose(power_good_output) |-> win_q >= 10'h2E9)
		else $error("power good rose too early");
	a_pg_fall_late: assert property ($fell(power_good_output) |-> out_q >= 10'h2E9)
		else $error("power good fell too early");
	a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus request not answered");
	a_wait_short: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("answer held too long");
	a_wait_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
		else $error("answer without request");
endmodule // pol_prot_sva

// file: pol_sys_watcher.sv
`timescale 1ns/1ps
module pol_sys_watcher (
	// Clock and reset
	input wire logic  clock,
	input wire logic  rst_n,
	// Watched pin
	input wire logic  power_good_output,
	output logic [7:0] pg_edges
);
	logic pg_q;
	// Both edges count, so a glitching pin shows up as a wrong total.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pg_q     <= 1'b0;
			pg_edges <= 8'h00;
		end else begin
			pg_q     <= power_good_output;
			pg_edges <= pg_edges + {7'h00, pg_q != power_good_output};
		end
	end
endmodule // pol_sys_watcher

// file: tb_pol_fault_protection_monitor.sv
`timescale 1ns/1ps
module tb_pol_fault_protection_monitor;
	logic              clock = 1'b0;
	logic              rst_n = 1'b0;
	logic [12:0]       vout_mv = 13'h0000;
	logic [12:0]       vset_mv = 13'h03E8;
	logic [12:0]       vramp_mv = 13'h01F4;
	logic              ramping_up = 1'b1;
	logic signed [9:0] temp_c = 10'sh019;
	logic [4:0]        avs_address = 5'h00;
	logic              avs_read = 1'b0;
	logic              avs_write = 1'b0;
	logic [31:0]       avs_writedata = 32'h0;
	logic [31:0]       avs_readdata, q;
	logic              turn_off, power_good_output, irq, avs_waitrequest;
	logic [7:0]        pg_edges;
	int                miscompares = 0;
	int                check_count = 0;
	int                cycles = 0;
	always #4 clock = ~clock;
	pol_fault_protection_monitor #(.RETRY_CYCLES(1000)) u_dut (.clock(clock), .rst_n(rst_n),
		.vout_mv(vout_mv), .vset_mv(vset_mv), .vramp_mv(vramp_mv), .ramping_up(ramping_up),
		.temp_c(temp_c), .turn_off(turn_off), .power_good_output(power_good_output),
		.irq(irq), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest));
	pol_sys_watcher u_sys (.clock(clock), .rst_n(rst_n),
		.power_good_output(power_good_output), .pg_edges(pg_edges));
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge clock);
		avs_address   <= a;
		avs_write     <= w;
		avs_read      <= !w;
		avs_writedata <= d;
		do @(posedge clock); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clock);
	endtask
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			miscompares++;
			results();
		end
	end
	initial begin
		wt(16);
		rst_n <= 1'b1;
		bus(0, 5'h00, 0); chk("ctrl", q, 32'h0);
		bus(0, 5'h1C, 0); chk("unmapped", q, 32'h0);
		vout_mv <= 13'h03E8;
		ramping_up <= 1'b0;
		wt(740); chk("pg early", 32'(power_good_output), 32'h0);
		wt(20); chk("pg", 32'(power_good_output), 32'h1);
		chk("irq masked", 32'(irq), 32'h0);
		bus(0, 5'h08, 0); chk("sticky", q, 32'h10);
		bus(1, 5'h0C, 32'h1F);
		wt(2); chk("irq", 32'(irq), 32'h1);
		bus(1, 5'h10, 32'h1F);
		wt(2); chk("irq clr", 32'(irq), 32'h0);
		$display("test power good rise done");
		vout_mv <= 13'h044C;
		wt(800); chk("pg 110", 32'(power_good_output), 32'h1);
		vout_mv <= 13'h044D;
		wt(760); chk("pg above", 32'(power_good_output), 32'h0);
		vout_mv <= 13'h0384;
		wt(760); chk("pg 90", 32'(power_good_output), 32'h1);
		bus(1, 5'h00, 32'h40);
		wt(760); chk("pg 95", 32'(power_good_output), 32'h0);
		vout_mv <= 13'h03B6;
		wt(760); chk("pg 95 in", 32'(power_good_output), 32'h1);
		bus(1, 5'h00, 32'h0);
		$display("test window done");
		vout_mv <= 13'h02F8;
		wt(800); chk("uv 76", 32'(turn_off), 32'h0);
		vout_mv <= 13'h02ED;
		wt(745); chk("uv early", 32'(turn_off), 32'h0);
		wt(20); chk("uv off", 32'(turn_off), 32'h1);
		bus(0, 5'h04, 0); chk("status uv", q, 32'h21);
		vout_mv <= 13'h03E8;
		wt(980); chk("retry early", 32'(turn_off), 32'h1);
		wt(10); chk("retry", 32'(turn_off), 32'h0);
		wt(800);
		bus(1, 5'h00, 32'h21);
		vout_mv <= 13'h0351;
		wt(770); chk("uv 85", 32'(turn_off), 32'h1);
		vout_mv <= 13'h03E8;
		wt(760); chk("latched", 32'(turn_off), 32'h1);
		bus(1, 5'h14, 32'h1);
		wt(3); chk("reenable", 32'(turn_off), 32'h0);
		bus(1, 5'h00, 32'h0);
		wt(800);
		$display("test undervoltage done");
		ramping_up <= 1'b1;
		vout_mv <= 13'h02F8;
		wt(800); chk("trk off", 32'(turn_off), 32'h0);
		bus(1, 5'h00, 32'h04);
		wt(770); bus(0, 5'h04, 0); chk("status trk", q, 32'h24);
		vout_mv <= 13'h02EE;
		wt(970); chk("trk retry early", 32'(turn_off), 32'h1);
		wt(10); chk("trk retry", 32'(turn_off), 32'h0);
		wt(800); chk("trk 250", 32'(turn_off), 32'h0);
		ramping_up <= 1'b0;
		vout_mv <= 13'h03E8;
		bus(1, 5'h00, 32'h0);
		$display("test tracking done");
		temp_c <= 10'sh077;
		wt(800);
		temp_c <= 10'sh078;
		wt(740); bus(0, 5'h04, 0); chk("warn early", q, 32'h10);
		wt(20); bus(0, 5'h04, 0); chk("warn", q, 32'h18);
		temp_c <= 10'sh076;
		wt(800); bus(0, 5'h04, 0); chk("warn hyst", q, 32'h18);
		temp_c <= 10'sh082;
		wt(745); chk("ot early", 32'(turn_off), 32'h0);
		wt(20); chk("ot off", 32'(turn_off), 32'h1);
		temp_c <= 10'sh079;
		wt(800); chk("ot hold", 32'(turn_off), 32'h1);
		temp_c <= 10'sh078;
		wt(800); chk("ot restart", 32'(turn_off), 32'h0);
		temp_c <= 10'sh075;
		wt(800); bus(0, 5'h04, 0); chk("warn clr", q, 32'h10);
		bus(0, 5'h08, 0); chk("events", q, 32'h1F);
		bus(0, 5'h0C, 0); chk("irq en", q, 32'h1F);
		chk("irq held", 32'(irq), 32'h1);
		chk("pg edges", 32'(pg_edges), 32'h0B);
		$display("test temperature done");
		results();
	end
endmodule // tb_pol_fault_protection_monitor
bind pol_fault_protection_monitor pol_prot_sva u_sva (.clock(clock), .rst_n(rst_n),
	.vout_mv(vout_mv), .vset_mv(vset_mv), .temp_c(temp_c), .turn_off(turn_off),
	.power_good_output(power_good_output), .avs_read(avs_read), .avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest));
